// ==== hdl/qum_cfg.svh ====
// Constants for the quad UART host select and modem pin block
`ifndef QUM_CFG_SVH
`define QUM_CFG_SVH
`define QUM_MCR_DTR_BIT      0
`define QUM_MCR_PRESCALE_BIT 7
`define QUM_MSR_CTS_BIT      4
`define QUM_MSR_DSR_BIT      5
`define QUM_MSR_CD_BIT       7
`define QUM_EFR_AUTOCTS_BIT  7
`define QUM_PRESCALE_DIV     4
`define QUM_MCR_RESET        8'h00
`define QUM_EFR_RESET        8'h00
`define QUM_CHANNELS         4
`define QUM_ADDR_MCR         3'h4
`define QUM_ADDR_MSR         3'h6
`define QUM_ADDR_EFR         3'h2
`endif

// ==== hdl/qum_pkg.sv ====
// Types for the quad UART host select and modem pin block
package qum_pkg;
   typedef enum logic {QUM_BUS_RW, QUM_BUS_STROBE} qum_bus_mode_t;
endpackage

// ==== hdl/qum_top.sv ====
// Host channel select, prescale choice and modem pins of a four channel UART
`timescale 1ns/100ps
`default_nettype none
`include "qum_cfg.svh"
module qum_top
   import qum_pkg::*;
#(
   parameter int SMALL_PACKAGE = 0
) (
   input  wire logic       CLK,
   input  wire logic       RESET_N,
   input  wire logic       CLK_EN,
   input  wire logic       BUS_MODE_SEL,
   input  wire logic       SHARED_SELECT_N,
   input  wire logic [1:0] UPPER_CHANNEL_ADDR,
   input  wire logic [1:0] STROBE_SELECT_N_HI,
   input  wire logic       PRESCALE_SELECT_PIN,
   input  wire logic       WRITE_STROBE,
   input  wire logic       READ_STROBE,
   input  wire logic [2:0] REG_ADDR,
   input  wire logic [7:0] HOST_DATA_BUS_IN,
   output var  logic [7:0] HOST_DATA_BUS_OUT,
   output var  logic       HOST_DATA_BUS_OE,
   input  wire logic [3:0] CARRIER_DETECT_N,
   input  wire logic [3:0] CLEAR_TO_SEND_N,
   input  wire logic [3:0] DATA_SET_READY_N,
   output var  logic [3:0] TERMINAL_READY_N,
   output var  logic [3:0] TX_PERMIT,
   output var  logic [3:0] PRESCALE_DIV4,
   output var  logic [3:0] CHANNEL_ACTIVE
);

   // Register offsets inside each channel; every other offset reads as zero
   localparam logic [2:0] ADDR_MCR = `QUM_ADDR_MCR;
   localparam logic [2:0] ADDR_MSR = `QUM_ADDR_MSR;
   localparam logic [2:0] ADDR_EFR = `QUM_ADDR_EFR;

   // Reset release through two stages
   // Assertion acts at once; release waits two edges so no flop sees it mid-edge
   logic rst_s1_ff;
   logic rst_n;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_s1_ff <= 1'b0;
         rst_n     <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n     <= rst_s1_ff;
      end
   end

   // Pin synchronisers; first stage feeds only second stage
   logic [14:0] pin_s1_ff;
   logic [14:0] pin_s2_ff;
   logic [14:0] pin_raw;
   assign pin_raw = {BUS_MODE_SEL, SHARED_SELECT_N, UPPER_CHANNEL_ADDR, STROBE_SELECT_N_HI,
                     PRESCALE_SELECT_PIN, CARRIER_DETECT_N, CLEAR_TO_SEND_N};
   // Data-set-ready kept apart; it only ever feeds the status read
   logic [3:0] dsr_s1_ff;
   logic [3:0] dsr_s2_ff;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= 15'h7FFF;
         pin_s2_ff <= 15'h7FFF;
         dsr_s1_ff <= 4'hF;
         dsr_s2_ff <= 4'hF;
      end else if (CLK_EN) begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
         dsr_s1_ff <= DATA_SET_READY_N;
         dsr_s2_ff <= dsr_s1_ff;
      end
   end

   // Synchronised pin fields, in the order of the raw vector
   logic       mode_pin;
   logic       cs_sh_n;
   logic [1:0] ua;
   logic [1:0] sel_bc_n;
   logic       presc_pin;
   logic [3:0] cd_n;
   logic [3:0] cts_n;
   assign {mode_pin, cs_sh_n, ua, sel_bc_n, presc_pin, cd_n, cts_n} = pin_s2_ff;

   // Small package is strapped to strobe mode
   qum_bus_mode_t bus_mode;
   assign bus_mode = (SMALL_PACKAGE != 0 || mode_pin) ? QUM_BUS_STROBE : QUM_BUS_RW;

   // Channel decode from select pins
   function automatic logic [3:0] decode_sel(input qum_bus_mode_t m, input logic csn,
                                             input logic [1:0] a, input logic [1:0] bc_n);
      logic [3:0] r;
      r = 4'h0;
      if (m == QUM_BUS_RW) begin
         if (!csn) r[a] = 1'b1;
      end else begin
         // Several selects may be low at once; each channel decodes alone
         r[0] = !csn;
         r[1] = !a[0];
         r[2] = !a[1];
         r[3] = !bc_n[1];
      end
      return r;
   endfunction

   // Combinational decode; its registered copy drives CHANNEL_ACTIVE
   logic [3:0] chan_sel;
   assign chan_sel = decode_sel(bus_mode, cs_sh_n, ua, sel_bc_n);

   // Per channel registers; status is live from the pins, not stored
   logic [7:0] mcr_ff [4];
   logic [7:0] nxt_mcr [4];
   logic [7:0] efr_ff [4];
   logic [7:0] nxt_efr [4];
   logic [7:0] dout_ff;
   logic [7:0] nxt_dout;
   logic       oe_ff;
   logic       nxt_oe;
   logic [3:0] dtr_n_ff;
   logic [3:0] nxt_dtr_n;
   logic [3:0] txp_ff;
   logic [3:0] nxt_txp;
   logic [3:0] div4_ff;
   logic [3:0] nxt_div4;
   logic [3:0] act_ff;
   logic [3:0] nxt_act;

   // Writes, reads and pin-facing outputs for every channel
   // Two channels read at once: the higher index wins the bus data
   always_comb begin
      nxt_dout = 8'h00;
      nxt_oe   = 1'b0;
      for (int i = 0; i < `QUM_CHANNELS; i++) begin
         nxt_mcr[i] = mcr_ff[i];
         nxt_efr[i] = efr_ff[i];
         if (chan_sel[i] && WRITE_STROBE) begin
            if (REG_ADDR == ADDR_MCR) nxt_mcr[i] = HOST_DATA_BUS_IN;
            if (REG_ADDR == ADDR_EFR) nxt_efr[i] = HOST_DATA_BUS_IN;
         end
         if (chan_sel[i] && READ_STROBE) begin
            nxt_oe = 1'b1;
            case (REG_ADDR)
               ADDR_MCR: nxt_dout = mcr_ff[i];
               ADDR_EFR: nxt_dout = efr_ff[i];
               ADDR_MSR: begin
                  nxt_dout[`QUM_MSR_CTS_BIT] = !cts_n[i];
                  nxt_dout[`QUM_MSR_DSR_BIT] = !dsr_s2_ff[i];
                  nxt_dout[`QUM_MSR_CD_BIT]  = !cd_n[i];
               end
               default: nxt_dout = 8'h00;
            endcase
         end
         nxt_dtr_n[i] = !mcr_ff[i][`QUM_MCR_DTR_BIT];
         // Auto flow only; otherwise clear-to-send is pure status
         nxt_txp[i] = efr_ff[i][`QUM_EFR_AUTOCTS_BIT] ? !cts_n[i] : 1'b1;
         // Register bit overrides the pin; small package has no pin
         nxt_div4[i] = mcr_ff[i][`QUM_MCR_PRESCALE_BIT] ||
                       (SMALL_PACKAGE == 0 && !presc_pin);
         nxt_act[i] = chan_sel[i];
      end
   end

   // Register stage; clock enable freezes everything
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `QUM_CHANNELS; i++) begin
            mcr_ff[i] <= `QUM_MCR_RESET;
            efr_ff[i] <= `QUM_EFR_RESET;
         end
         dout_ff  <= 8'h00;
         oe_ff    <= 1'b0;
         dtr_n_ff <= 4'hF;
         txp_ff   <= 4'hF;
         div4_ff  <= 4'h0;
         act_ff   <= 4'h0;
      end else if (CLK_EN) begin
         for (int i = 0; i < `QUM_CHANNELS; i++) begin
            mcr_ff[i] <= nxt_mcr[i];
            efr_ff[i] <= nxt_efr[i];
         end
         dout_ff  <= nxt_dout;
         oe_ff    <= nxt_oe;
         dtr_n_ff <= nxt_dtr_n;
         txp_ff   <= nxt_txp;
         div4_ff  <= nxt_div4;
         act_ff   <= nxt_act;
      end
   end

   // Every output straight from its flip-flop
   assign HOST_DATA_BUS_OUT = dout_ff;
   assign HOST_DATA_BUS_OE  = oe_ff;
   assign TERMINAL_READY_N  = dtr_n_ff;
   assign TX_PERMIT         = txp_ff;
   assign PRESCALE_DIV4     = div4_ff;
   assign CHANNEL_ACTIVE    = act_ff;

   // Terminal ready and flow control checks
   chk_dtr_follows_mcr: assert property (@(posedge CLK) disable iff (!rst_n)
      CLK_EN |=> (TERMINAL_READY_N[0] == !$past(mcr_ff[0][`QUM_MCR_DTR_BIT])))
      else $error("terminal ready does not follow control bit");
   chk_dtr_ch3_mcr: assert property (@(posedge CLK) disable iff (!rst_n)
      CLK_EN |=> (TERMINAL_READY_N[3] == !$past(mcr_ff[3][`QUM_MCR_DTR_BIT])))
      else $error("channel D terminal ready does not follow control bit");
   chk_txp_status_only: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && !efr_ff[1][`QUM_EFR_AUTOCTS_BIT]) |=> TX_PERMIT[1])
      else $error("clear to send gated without flow control");
   chk_txp_follows_cts: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && efr_ff[2][`QUM_EFR_AUTOCTS_BIT]) |=> TX_PERMIT[2] == !$past(cts_n[2]))
      else $error("flow control does not follow clear to send");

   // Channel decode checks
   chk_rw_one_hot: assert property (@(posedge CLK) disable iff (!rst_n)
      (bus_mode == QUM_BUS_RW) |-> $onehot0(chan_sel))
      else $error("more than one channel in read write mode");
   chk_rw_addr_pick: assert property (@(posedge CLK) disable iff (!rst_n)
      (bus_mode == QUM_BUS_RW && !cs_sh_n) |-> chan_sel == (4'h1 << ua))
      else $error("upper address picks the wrong channel");
   chk_rw_csn_gate: assert property (@(posedge CLK) disable iff (!rst_n)
      (bus_mode == QUM_BUS_RW && cs_sh_n) |-> chan_sel == 4'h0)
      else $error("channel selected without shared select");
   chk_strobe_a_sel: assert property (@(posedge CLK) disable iff (!rst_n)
      (bus_mode == QUM_BUS_STROBE) |-> chan_sel[0] == !cs_sh_n)
      else $error("channel A select misdecoded");
   chk_strobe_b_sel: assert property (@(posedge CLK) disable iff (!rst_n)
      (bus_mode == QUM_BUS_STROBE) |-> chan_sel[1] == !ua[0])
      else $error("channel B select misdecoded");
   chk_strobe_c_sel: assert property (@(posedge CLK) disable iff (!rst_n)
      (bus_mode == QUM_BUS_STROBE) |-> chan_sel[2] == !ua[1])
      else $error("channel C select misdecoded");
   chk_strobe_d_sel: assert property (@(posedge CLK) disable iff (!rst_n)
      (bus_mode == QUM_BUS_STROBE) |-> chan_sel[3] == !sel_bc_n[1])
      else $error("channel D select misdecoded");

   // Register write and clock enable checks
   chk_no_write_unsel: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && !chan_sel[2]) |=> $stable(mcr_ff[2]))
      else $error("unselected channel register changed");
   chk_efr_hold_unsel: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && !chan_sel[0]) |=> $stable(efr_ff[0]))
      else $error("unselected channel feature register changed");
   chk_mcr_write_lands: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && chan_sel[1] && WRITE_STROBE && REG_ADDR == ADDR_MCR)
      |=> mcr_ff[1] == $past(HOST_DATA_BUS_IN))
      else $error("selected channel control write lost");
   chk_efr_write_lands: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && chan_sel[3] && WRITE_STROBE && REG_ADDR == ADDR_EFR)
      |=> efr_ff[3] == $past(HOST_DATA_BUS_IN))
      else $error("selected channel feature write lost");
   chk_freeze_mcr: assert property (@(posedge CLK) disable iff (!rst_n)
      (!CLK_EN) |=> $stable(mcr_ff[0]) && $stable(TERMINAL_READY_N))
      else $error("state moved while clock enable low");

   // Prescale checks
   chk_prescale_pin: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && !mcr_ff[3][`QUM_MCR_PRESCALE_BIT] && SMALL_PACKAGE == 0) |=> PRESCALE_DIV4[3] == !$past(presc_pin))
      else $error("prescale does not follow pin");
   chk_prescale_ovr: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && mcr_ff[3][`QUM_MCR_PRESCALE_BIT]) |=> PRESCALE_DIV4[3])
      else $error("prescale override ignored");

   // Host bus and status checks
   chk_cts_status: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && chan_sel == 4'h1 && READ_STROBE && REG_ADDR == ADDR_MSR)
      |=> HOST_DATA_BUS_OE && HOST_DATA_BUS_OUT[`QUM_MSR_CTS_BIT] == !$past(cts_n[0]))
      else $error("clear to send status bit wrong");
   chk_dsr_status: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && chan_sel == 4'h2 && READ_STROBE && REG_ADDR == ADDR_MSR)
      |=> HOST_DATA_BUS_OUT[`QUM_MSR_DSR_BIT] == !$past(dsr_s2_ff[1]))
      else $error("data set ready status bit wrong");
   chk_cd_status: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && chan_sel == 4'h4 && READ_STROBE && REG_ADDR == ADDR_MSR)
      |=> HOST_DATA_BUS_OUT[`QUM_MSR_CD_BIT] == !$past(cd_n[2]))
      else $error("carrier detect status bit wrong");
   chk_unmapped_zero: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && chan_sel == 4'h1 && READ_STROBE && REG_ADDR == 3'h7)
      |=> HOST_DATA_BUS_OUT == 8'h00)
      else $error("unmapped offset does not read zero");
   chk_bus_drive_read: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && READ_STROBE && chan_sel != 4'h0) |=> HOST_DATA_BUS_OE)
      else $error("data bus not driven on read");
   chk_bus_release: assert property (@(posedge CLK) disable iff (!rst_n)
      (CLK_EN && !READ_STROBE) |=> !HOST_DATA_BUS_OE)
      else $error("data bus driven without read");

   // Synchroniser depth check
   chk_sync_two_stage: assert property (@(posedge CLK) disable iff (!rst_n)
      (rst_n && $past(rst_n) && CLK_EN && $past(CLK_EN))
      |=> cts_n == $past(CLEAR_TO_SEND_N, 2))
      else $error("clear to send not delayed by two stages");

endmodule // qum_top
`default_nettype wire

// ==== dv/qum_modem_model.sv ====
// Behavioural modem driving the four channels' status pins
`timescale 1ns/100ps
`default_nettype none
module qum_modem_model (
   input  wire logic       clk,
   input  wire logic [3:0] carrier,
   input  wire logic [3:0] ready_rx,
   input  wire logic [3:0] powered,
   output var  logic [3:0] carrier_detect_n,
   output var  logic [3:0] clear_to_send_n,
   output var  logic [3:0] data_set_ready_n
);
   // Pins move on the clock only, asynchronous to nothing in the bench
   always_ff @(posedge clk) begin
      carrier_detect_n <= ~carrier;
      clear_to_send_n  <= ~ready_rx;
      data_set_ready_n <= ~powered;
   end
endmodule // qum_modem_model
`default_nettype wire

// ==== dv/quad_uart_host_select_modem_pins_tb_top.sv ====
// Self-checking bench for the host select and modem pin block
`timescale 1ns/100ps
`default_nettype none
module quad_uart_host_select_modem_pins_tb_top;
   logic       clk = 1'b0, rst_n = 1'b0, mode = 1'b0, shr_n = 1'b1;
   logic       we = 1'b0, re = 1'b0, pre_pin = 1'b1, oe, en = 1'b1;
   logic [1:0] up = 2'h3, hi_n = 2'h3;
   logic [2:0] addr = 3'h0;
   logic [7:0] din = 8'h00, dout, d;
   logic [3:0] cd = 4'h0, cts = 4'h0, dsr = 4'h0, cd_n, cts_n, dsr_n, dtr_n, txp, div4, act;
   logic [7:0] modem_control_reg [4] = '{default: 8'h00};
   logic [7:0] enhanced_feature_reg [4] = '{default: 8'h00};
   int         miscompares = 0, checked = 0;

   always #2 clk = ~clk;

   qum_top i_qum_top (.CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .BUS_MODE_SEL(mode),
      .SHARED_SELECT_N(shr_n), .UPPER_CHANNEL_ADDR(up), .STROBE_SELECT_N_HI(hi_n),
      .PRESCALE_SELECT_PIN(pre_pin), .WRITE_STROBE(we), .READ_STROBE(re), .REG_ADDR(addr),
      .HOST_DATA_BUS_IN(din), .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe),
      .CARRIER_DETECT_N(cd_n), .CLEAR_TO_SEND_N(cts_n), .DATA_SET_READY_N(dsr_n),
      .TERMINAL_READY_N(dtr_n), .TX_PERMIT(txp), .PRESCALE_DIV4(div4), .CHANNEL_ACTIVE(act));
   qum_modem_model i_qum_modem_model (.clk(clk), .carrier(cd), .ready_rx(cts),
      .powered(dsr), .carrier_detect_n(cd_n), .clear_to_send_n(cts_n),
      .data_set_ready_n(dsr_n));

   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   // Channel 4 means nobody selected; selects lead strobes by their sync delay
   task automatic sel(int ch);
      shr_n <= mode ? (ch != 0) : (ch > 3);
      up    <= mode ? {ch != 2, ch != 1} : ch[1:0];
      hi_n  <= {!mode || ch != 3, 1'b1};
      cyc(3);
   endtask
   task automatic wr(int ch, logic [2:0] a, logic [7:0] v);
      sel(ch);
      addr <= a;
      din <= v;
      we <= 1'b1;
      cyc(1);
      we <= 1'b0;
      cyc(3);
      // A write made while the clock enable is low must be lost
      if (en) chk("active", {4'h0, act}, (ch < 4) ? 8'(1 << ch) : 8'h00);
      if (en && ch < 4 && a == 3'h4) modem_control_reg[ch] = v;
      if (en && ch < 4 && a == 3'h2) enhanced_feature_reg[ch] = v;
   endtask
   task automatic rd(int ch, logic [2:0] a);
      sel(ch);
      addr <= a;
      re <= 1'b1;
      cyc(1);
      re <= 1'b0;
      #1 d = dout;
      chk("oe", {7'h0, oe}, 8'h01);
      cyc(1);
   endtask
   task automatic pins();
      for (int c = 0; c < 4; c++) begin
         chk("dtr_n", {7'h0, dtr_n[c]}, {7'h0, ~modem_control_reg[c][0]});
         chk("tx_permit", {7'h0, txp[c]}, {7'h0, ~enhanced_feature_reg[c][7] | cts[c]});
         chk("div4", {7'h0, div4[c]}, {7'h0, modem_control_reg[c][7] | ~pre_pin});
      end
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Guard against a hung run
   initial begin
      cyc(20000);
      miscompares++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'hAF33));
      cyc(10);
      rst_n <= 1'b1;
      cyc(6);
      pins();
      // Both bus modes, every channel plus an unselected write
      for (int m = 0; m < 2; m++) begin
         mode <= m[0];
         // Let the new mode land before the selects are worked out from it
         cyc(1);
         for (int c = 0; c < 5; c++) begin
            {cd, cts, dsr} <= 12'($urandom);
            pre_pin <= 1'($urandom);
            wr(c, 3'h4, 8'($urandom));
            wr(c, 3'h2, 8'($urandom));
            pins();
            if (c < 4) begin
               rd(c, 3'h6);
               chk("msr", d & 8'hB0, {cd[c], 1'b0, dsr[c], cts[c], 4'h0});
            end
         end
      end
      // Clock enable low: an inverted control write must not land
      en <= 1'b0;
      wr(1, 3'h4, ~modem_control_reg[1]);
      en <= 1'b1;
      cyc(4);
      pins();
      // Unmapped register reads as zero
      rd(0, 3'h7);
      chk("unmapped", d, 8'h00);
      end_of_test();
   end
endmodule // quad_uart_host_select_modem_pins_tb_top
`default_nettype wire
